// *** rtl/comm_fault_debug_flags.v ***
// Operation
// - A malformed response byte on the host serial port, other than the init byte, sets the byte-fault flag.
// - After a byte fault every received byte is ignored until a communication clear is seen.
// - An ignored frame gets no error detection and raises no fault flags.
// - An ignored frame bumps neither the valid-frame nor the discarded-frame counter.
// - A CRC mismatch in a response frame sets the CRC-fault flag and counts the frame as discarded.
// - The bad-frame tag flag follows the marker of the last upper-port frame and is 0 otherwise.
// - Timing locked from preamble and sync but no data recovered sets the timing-locked-no-data flag.
// - Receive bit timing is taken from the detected preamble half-bit and both sync bits.
// - A missing or distorted preamble half-bit or sync bit sets the preamble-missing flag.
// - A data bit with too few samples for a firm 1 or 0 sets the weak-bit flag.
`timescale 1ns/1ps
`include "comm_fault_defines.vh"

module comm_fault_debug_flags (
	input  wire        sys_clk,
	input  wire        rst,
	// Wishbone slave
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [15:0] wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	output reg         irq,
	// Host serial port response receiver
	input  wire        uart_byte_done,
	input  wire        uart_byte_is_init,
	input  wire        uart_byte_malformed,
	input  wire        uart_frame_end,
	input  wire        uart_crc_ok,
	input  wire        uart_clear_det,
	output reg         rsp_ignoring,
	output reg         rsp_valid_frame_inc,
	output reg         rsp_discard_frame_inc,
	// Upper chain port bit receiver
	input  wire        chain_sync_check,
	input  wire        chain_preamble_half_ok,
	input  wire [1:0]  chain_sync_bit_pair,
	input  wire [7:0]  chain_edge_interval,
	input  wire        chain_data_timeout,
	input  wire        chain_bit_done,
	input  wire [3:0]  chain_bit_ones,
	input  wire [3:0]  chain_bit_zeros,
	input  wire        chain_frame_end,
	input  wire        chain_frame_bad_marker,
	output reg         chain_timing_locked,
	output reg  [7:0]  chain_bit_timing
);

	localparam ST_RECV   = 1'b0;
	localparam ST_IGNORE = 1'b1;

	// ==========================================================
	// Declarations
	reg         rsp_state_r;
	reg         rsp_state_nxt;
	reg         rsp_byte_fault_set;
	reg         rsp_crc_fault_set;
	reg         valid_inc_nxt;
	reg         discard_inc_nxt;
	reg         bad_tag_r;
	reg         weak_set;
	reg         preamble_set;
	reg         no_data_set;
	reg         lock_nxt;
	reg  [5:0]  irq_mask_r;
	reg  [31:0] rd_data;
	wire        wb_req;
	wire        wb_wr;
	wire        wr_flag_clr;
	wire        wr_irq_status;
	wire        wr_irq_mask;
	wire        bad_tag_event;
	wire        sync_all_ok;
	wire        firm_bit;
	wire [1:0]  rsp_set;
	wire [1:0]  rsp_clr;
	wire [2:0]  bit_set;
	wire [2:0]  bit_clr;
	wire [5:0]  irq_set;
	wire [5:0]  irq_clr;
	wire [1:0]  rsp_flags;
	wire [2:0]  bit_flags;
	wire [5:0]  irq_status;
	wire [7:0]  uart_reg;
	wire [7:0]  upper_reg;

	assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wb_wr  = wb_req & wb_we_i & wb_sel_i[0];

	// ==========================================================
	// Register write decode
	assign wr_flag_clr   = wb_wr & (wb_adr_i == `ADDR_FLAG_CLEAR);
	assign wr_irq_status = wb_wr & (wb_adr_i == `ADDR_IRQ_STATUS);
	assign wr_irq_mask   = wb_wr & (wb_adr_i == `ADDR_IRQ_MASK);

	// ==========================================================
	// Response frame receive state
	always @* begin
		rsp_state_nxt      = rsp_state_r;
		rsp_byte_fault_set = 1'b0;
		rsp_crc_fault_set  = 1'b0;
		valid_inc_nxt      = 1'b0;
		discard_inc_nxt    = 1'b0;
		case (rsp_state_r)
			ST_RECV: begin
				if (uart_byte_done && uart_byte_malformed && !uart_byte_is_init) begin
					rsp_byte_fault_set = 1'b1;
					rsp_state_nxt      = ST_IGNORE;
				end else if (uart_frame_end) begin
					if (uart_crc_ok) begin
						valid_inc_nxt     = 1'b1;
					end else begin
						rsp_crc_fault_set = 1'b1;
						discard_inc_nxt   = 1'b1;
					end
				end
			end
			ST_IGNORE: begin
				if (uart_clear_det) begin
					rsp_state_nxt = ST_RECV;
				end
			end
			default: begin
				rsp_state_nxt = ST_RECV;
			end
		endcase
	end

	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rsp_state_r           <= ST_RECV;
			rsp_ignoring          <= 1'b0;
			rsp_valid_frame_inc   <= 1'b0;
			rsp_discard_frame_inc <= 1'b0;
		end else begin
			rsp_state_r           <= rsp_state_nxt;
			rsp_ignoring          <= (rsp_state_nxt == ST_IGNORE);
			rsp_valid_frame_inc   <= valid_inc_nxt;
			rsp_discard_frame_inc <= discard_inc_nxt;
		end
	end

	// ==========================================================
	// Upper chain port bit checks
	assign sync_all_ok = chain_preamble_half_ok & (&chain_sync_bit_pair);
	assign firm_bit    = (chain_bit_ones >= `FIRM_SAMPLE_COUNT) ||
	                     (chain_bit_zeros >= `FIRM_SAMPLE_COUNT);

	always @* begin
		lock_nxt     = chain_timing_locked;
		preamble_set = 1'b0;
		no_data_set  = 1'b0;
		weak_set     = 1'b0;
		if (chain_sync_check) begin
			preamble_set = ~sync_all_ok;
			lock_nxt     = sync_all_ok;
		end else if (chain_frame_end) begin
			lock_nxt = 1'b0;
		end
		if (chain_timing_locked && chain_data_timeout) begin
			no_data_set = 1'b1;
		end
		if (chain_bit_done && !firm_bit) begin
			weak_set = 1'b1;
		end
	end

	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			chain_timing_locked <= 1'b0;
			chain_bit_timing    <= `RST_TIMING;
			bad_tag_r           <= 1'b0;
		end else begin
			chain_timing_locked <= lock_nxt;
			if (chain_sync_check && sync_all_ok) begin
				chain_bit_timing <= chain_edge_interval;
			end
			if (chain_frame_end) begin
				bad_tag_r <= chain_frame_bad_marker;
			end
		end
	end

	// ==========================================================
	// Sticky flags and interrupt status
	assign rsp_set[`BIT_RSP_CRC_FAULT]    = rsp_crc_fault_set;
	assign rsp_set[`BIT_RSP_BYTE_FAULT]   = rsp_byte_fault_set;
	assign rsp_clr                        = {2{wr_flag_clr & wb_dat_i[`BIT_CLR_UART]}};
	assign bit_set[`BIT_WEAK_BIT]         = weak_set;
	assign bit_set[`BIT_PREAMBLE_MISSING] = preamble_set;
	assign bit_set[`BIT_TIMING_NO_DATA]   = no_data_set;
	assign bit_clr                        = {3{wr_flag_clr & wb_dat_i[`BIT_CLR_UPPER]}};
	assign bad_tag_event                  = chain_frame_end & chain_frame_bad_marker;
	assign irq_set[`BIT_IRQ_RSP_CRC]      = rsp_crc_fault_set;
	assign irq_set[`BIT_IRQ_RSP_BYTE]     = rsp_byte_fault_set;
	assign irq_set[`BIT_IRQ_BAD_TAG]      = bad_tag_event;
	assign irq_set[`BIT_IRQ_NO_DATA]      = no_data_set;
	assign irq_set[`BIT_IRQ_PREAMBLE]     = preamble_set;
	assign irq_set[`BIT_IRQ_WEAK]         = weak_set;
	assign irq_clr                        = wr_irq_status ? wb_dat_i[5:0] : 6'h00;

	sticky_bits #(
		.WIDTH (2)
	) u_rsp_flags (
		.sys_clk (sys_clk),
		.rst     (rst),
		.set     (rsp_set),
		.clr     (rsp_clr),
		.q       (rsp_flags)
	);

	sticky_bits #(
		.WIDTH (3)
	) u_bit_flags (
		.sys_clk (sys_clk),
		.rst     (rst),
		.set     (bit_set),
		.clr     (bit_clr),
		.q       (bit_flags)
	);

	sticky_bits #(
		.WIDTH (6)
	) u_irq_status (
		.sys_clk (sys_clk),
		.rst     (rst),
		.set     (irq_set),
		.clr     (irq_clr),
		.q       (irq_status)
	);

	assign uart_reg[7:2]                    = 6'h00;
	assign uart_reg[`BIT_RSP_BYTE_FAULT]    = rsp_flags[`BIT_RSP_BYTE_FAULT];
	assign uart_reg[`BIT_RSP_CRC_FAULT]     = rsp_flags[`BIT_RSP_CRC_FAULT];
	assign upper_reg[7:4]                   = 4'h0;
	assign upper_reg[`BIT_BAD_FRAME_TAG]    = bad_tag_r;
	assign upper_reg[`BIT_TIMING_NO_DATA]   = bit_flags[`BIT_TIMING_NO_DATA];
	assign upper_reg[`BIT_PREAMBLE_MISSING] = bit_flags[`BIT_PREAMBLE_MISSING];
	assign upper_reg[`BIT_WEAK_BIT]         = bit_flags[`BIT_WEAK_BIT];

	// ==========================================================
	// Register read mux
	always @* begin
		rd_data = 32'h0000_0000;
		case (wb_adr_i)
			`ADDR_UART_RSP_FLAGS:  rd_data = {24'h00_0000, uart_reg};
			`ADDR_UPPER_BIT_FLAGS: rd_data = {24'h00_0000, upper_reg};
			`ADDR_IRQ_STATUS:      rd_data = {26'h000_0000, irq_status};
			`ADDR_IRQ_MASK:        rd_data = {26'h000_0000, irq_mask_r};
			default:               rd_data = 32'h0000_0000;
		endcase
	end

	// ==========================================================
	// Wishbone slave
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_req;
		end
	end

	// Read data registered alongside ack
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (wb_req) begin
			wb_dat_o <= wb_we_i ? 32'h0000_0000 : rd_data;
		end
	end

	// ==========================================================
	// Interrupt mask and output
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			irq_mask_r <= `RST_IRQ_MASK;
		end else if (wr_irq_mask) begin
			irq_mask_r <= wb_dat_i[5:0];
		end
	end

	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |((irq_set | (irq_status & ~irq_clr)) & irq_mask_r);
		end
	end

endmodule

// *** rtl/comm_fault_defines.vh ***
`ifndef COMM_FAULT_DEFINES_VH
`define COMM_FAULT_DEFINES_VH

// ==========================================================
// Register indices and byte addresses
`define IDX_UART_RSP_FLAGS      12'h782
`define IDX_UPPER_BIT_FLAGS     12'h783
`define IDX_IRQ_STATUS          12'h790
`define IDX_IRQ_MASK            12'h791
`define IDX_FLAG_CLEAR          12'h792
`define ADDR_UART_RSP_FLAGS     16'h1e08
`define ADDR_UPPER_BIT_FLAGS    16'h1e0c
`define ADDR_IRQ_STATUS         16'h1e40
`define ADDR_IRQ_MASK           16'h1e44
`define ADDR_FLAG_CLEAR         16'h1e48

// ==========================================================
// Field positions
`define BIT_RSP_CRC_FAULT       0
`define BIT_RSP_BYTE_FAULT      1
`define BIT_WEAK_BIT            0
`define BIT_PREAMBLE_MISSING    1
`define BIT_TIMING_NO_DATA      2
`define BIT_BAD_FRAME_TAG       3
`define BIT_IRQ_RSP_CRC         0
`define BIT_IRQ_RSP_BYTE        1
`define BIT_IRQ_BAD_TAG         2
`define BIT_IRQ_NO_DATA         3
`define BIT_IRQ_PREAMBLE        4
`define BIT_IRQ_WEAK            5
`define BIT_CLR_UART            0
`define BIT_CLR_UPPER           1

// ==========================================================
// Reset values and timing
`define RST_FLAGS               8'h00
`define RST_IRQ_MASK            6'h00
`define RST_TIMING              8'h00
`define FIRM_SAMPLE_COUNT       4'h3

`endif

// *** rtl/sticky_bits.v ***
`timescale 1ns/1ps

// ==========================================================
// Sticky bit vector, set wins over clear
module sticky_bits #(
	parameter WIDTH = 2
) (
	input  wire             sys_clk,
	input  wire             rst,
	input  wire [WIDTH-1:0] set,
	input  wire [WIDTH-1:0] clr,
	output reg  [WIDTH-1:0] q
);

	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			q <= {WIDTH{1'b0}};
		end else begin
			q <= set | (q & ~clr);
		end
	end

endmodule

// *** testbench/comm_fault_debug_flags_properties.sv ***
`timescale 1ns/1ps
// ==========================================================
// Checker on response and chain flag ports
module comm_fault_debug_flags_properties (
	input wire       sys_clk,
	input wire       rst,
	input wire       uart_byte_done,
	input wire       uart_byte_is_init,
	input wire       uart_byte_malformed,
	input wire       uart_frame_end,
	input wire       uart_crc_ok,
	input wire       uart_clear_det,
	input wire       rsp_ignoring,
	input wire       rsp_valid_frame_inc,
	input wire       rsp_discard_frame_inc,
	input wire       chain_sync_check,
	input wire       chain_preamble_half_ok,
	input wire [1:0] chain_sync_bit_pair,
	input wire [7:0] chain_edge_interval,
	input wire       chain_frame_end,
	input wire       chain_timing_locked,
	input wire [7:0] chain_bit_timing
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	wire fault   = uart_byte_done && !uart_byte_is_init && uart_byte_malformed;
	wire lock_ok = chain_preamble_half_ok && (&chain_sync_bit_pair);
	wire fr_ok   = uart_frame_end && !rsp_ignoring && !fault;
	sequence clr_s;
		uart_clear_det && !uart_byte_done;
	endsequence
	a_fault_starts_ignore: assert property (fault && !uart_clear_det |=> rsp_ignoring)
		else $error("byte fault did not start ignoring");
	a_ignore_holds: assert property (rsp_ignoring && !uart_clear_det |=> rsp_ignoring)
		else $error("ignoring ended without clear");
	a_clear_resumes: assert property (clr_s |=> !rsp_ignoring)
		else $error("clear did not end ignoring");
	a_ignored_uncounted: assert property (rsp_ignoring && uart_frame_end
		|=> !rsp_valid_frame_inc && !rsp_discard_frame_inc)
		else $error("ignored frame was counted");
	a_crc_discards: assert property (fr_ok && !uart_crc_ok
		|=> rsp_discard_frame_inc && !rsp_valid_frame_inc)
		else $error("crc mismatch not discarded");
	a_good_frame_valid: assert property (fr_ok && uart_crc_ok
		|=> rsp_valid_frame_inc && !rsp_discard_frame_inc)
		else $error("good frame not counted valid");
	a_lock_captures: assert property (chain_sync_check && lock_ok && !chain_frame_end
		|=> chain_timing_locked && chain_bit_timing == $past(chain_edge_interval))
		else $error("timing not captured on good sync");
	a_sync_fail_unlocks: assert property (chain_sync_check && !lock_ok |=> !chain_timing_locked)
		else $error("lock held after failed sync");
endmodule

bind comm_fault_debug_flags comm_fault_debug_flags_properties u_props (.*);

// *** testbench/rx_source.sv ***
`timescale 1ns/1ps
// ==========================================================
// Receiver event source standing for host port and chain neighbour
module rx_source (
	input  wire        sys_clk,
	output reg  [31:0] ev
);
	localparam [31:0] strobes = 32'h100c_0069;
	initial ev = 32'h0000_0000;
	// One strobe with qualifiers, then qualifiers inverted once released
	task pulse(input [4:0] s, input [31:0] q);
		begin
			@(posedge sys_clk);
			ev <= q | (32'h0000_0001 << s);
			@(posedge sys_clk);
			ev <= ~q & ~strobes;
		end
	endtask
endmodule

// *** testbench/comm_fault_debug_flags_test.sv ***
`timescale 1ns/1ps
module comm_fault_debug_flags_test;
	localparam [31:0] z = 32'h0000_0000;
	localparam [31:0] o = 32'h0000_0001;
	reg         sys_clk = 0, rst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
	reg  [15:0] wb_adr_i = 16'h0000;
	reg  [3:0]  wb_sel_i = 4'hf;
	reg  [31:0] wb_dat_i = 32'h0000_0000;
	wire [31:0] wb_dat_o, ev;
	wire [7:0]  chain_bit_timing;
	wire        wb_ack_o, irq, rsp_ignoring, chain_timing_locked, v_inc, d_inc;
	integer     failures = 0, checks_done = 0;
	integer     n_valid = 0, n_disc = 0;
	rx_source p (.sys_clk(sys_clk), .ev(ev));
	comm_fault_debug_flags dut (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq),
		.uart_byte_done(ev[0]), .uart_byte_is_init(ev[1]), .uart_byte_malformed(ev[2]),
		.uart_frame_end(ev[3]), .uart_crc_ok(ev[4]), .uart_clear_det(ev[5]),
		.rsp_ignoring(rsp_ignoring), .rsp_valid_frame_inc(v_inc), .rsp_discard_frame_inc(d_inc),
		.chain_sync_check(ev[6]), .chain_preamble_half_ok(ev[7]),
		.chain_sync_bit_pair(ev[9:8]), .chain_edge_interval(ev[17:10]),
		.chain_data_timeout(ev[18]), .chain_bit_done(ev[19]), .chain_bit_ones(ev[23:20]),
		.chain_bit_zeros(ev[27:24]), .chain_frame_end(ev[28]),
		.chain_frame_bad_marker(ev[29]), .chain_timing_locked(chain_timing_locked),
		.chain_bit_timing(chain_bit_timing));
	initial forever #2.5 sys_clk = ~sys_clk;
	// Frame counter pulses seen from the response receiver
	always @(posedge sys_clk) begin
		if (v_inc === 1'b1) n_valid <= n_valid + 1;
		if (d_inc === 1'b1) n_disc <= n_disc + 1;
	end
	// ==========================================================
	// Shared tasks
	task chk(input [31:0] g, input [31:0] e);
		begin
			checks_done = checks_done + 1;
			if (g !== e) begin
				$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
				failures = failures + 1;
			end
		end
	endtask
	task bus(input w, input [15:0] a, input [31:0] d, output [31:0] q);
		integer n;
		begin
			@(posedge sys_clk);
			wb_cyc_i <= 1;
			wb_stb_i <= 1;
			wb_we_i <= w;
			wb_adr_i <= a;
			wb_dat_i <= d;
			n = 0;
			@(posedge sys_clk);
			while (wb_ack_o !== 1'b1 && n < 20) begin
				n = n + 1;
				@(posedge sys_clk);
			end
			if (n == 20) failures = failures + 1;
			q = wb_dat_o;
			wb_cyc_i <= 0;
			wb_stb_i <= 0;
		end
	endtask
	task rc(input [15:0] a, input [31:0] e);
		reg [31:0] q;
		begin
			bus(1'b0, a, z, q);
			chk(q, e);
		end
	endtask
	task ww(input [15:0] a, input [31:0] d);
		reg [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task test_done;
		begin
			$display("checks %0d failures %0d", checks_done, failures);
			if (failures == 0 && checks_done > 0) begin
				$display("ALL TESTS PASSED");
			end else begin
				$display("TESTS FAILED");
			end
			$finish;
		end
	endtask
	// ==========================================================
	// Scenarios
	task t_reset;
		begin
			rc(16'h1e08, z);
			rc(16'h1e0c, z);
			rc(16'h1e44, z);
			rc(16'h1e40, z);
			chk(32'(irq), z);
			rc(16'h0100, z);
		end
	endtask
	task t_crc_irq;
		begin
			p.pulse(5'd3, 32'h0000_0010);
			rc(16'h1e08, z);
			p.pulse(5'd3, z);
			rc(16'h1e08, o);
			chk(n_valid, o);
			chk(n_disc, o);
			rc(16'h1e40, o);
			chk(32'(irq), z);
			wb_sel_i <= 4'h0;
			ww(16'h1e44, o);
			rc(16'h1e44, z);
			wb_sel_i <= 4'hf;
			ww(16'h1e44, o);
			repeat (2) @(posedge sys_clk);
			chk(32'(irq), o);
			ww(16'h1e40, o);
			repeat (2) @(posedge sys_clk);
			chk(32'(irq), z);
			ww(16'h1e48, o);
			rc(16'h1e08, z);
		end
	endtask
	task t_ignore;
		begin
			p.pulse(5'd0, 32'h0000_0006);
			rc(16'h1e08, z);
			p.pulse(5'd0, 32'h0000_0004);
			@(posedge sys_clk);
			chk(32'(rsp_ignoring), o);
			rc(16'h1e08, 32'h0000_0002);
			ww(16'h1e48, o);
			p.pulse(5'd3, z);
			p.pulse(5'd0, 32'h0000_0004);
			rc(16'h1e08, z);
			chk(n_disc, o);
			chk(n_valid, o);
			p.pulse(5'd5, z);
			@(posedge sys_clk);
			chk(32'(rsp_ignoring), z);
			p.pulse(5'd3, z);
			rc(16'h1e08, o);
			chk(n_disc, 32'h0000_0002);
			chk(n_valid, o);
		end
	endtask
	task t_chain;
		begin
			p.pulse(5'd6, 32'h0001_6b80);
			@(posedge sys_clk);
			chk(32'(chain_bit_timing), 32'h0000_005a);
			p.pulse(5'd18, z);
			rc(16'h1e0c, 32'h0000_0004);
			p.pulse(5'd19, 32'h0030_0000);
			rc(16'h1e0c, 32'h0000_0004);
			p.pulse(5'd19, 32'h0120_0000);
			rc(16'h1e0c, 32'h0000_0005);
			p.pulse(5'd28, 32'h2000_0000);
			rc(16'h1e0c, 32'h0000_000d);
			p.pulse(5'd28, z);
			rc(16'h1e0c, 32'h0000_0005);
			ww(16'h1e48, 32'h0000_0002);
			p.pulse(5'd18, z);
			rc(16'h1e0c, z);
			p.pulse(5'd6, 32'h0001_6b80);
			@(posedge sys_clk);
			chk(32'(chain_timing_locked), o);
			p.pulse(5'd6, 32'h0000_0180);
			rc(16'h1e0c, 32'h0000_0002);
			chk(32'(chain_timing_locked), z);
		end
	endtask
	task t_mid_reset;
		begin
			@(posedge sys_clk);
			rst <= 1;
			repeat (2) @(posedge sys_clk);
			rst <= 0;
			rc(16'h1e08, z);
			rc(16'h1e0c, z);
			rc(16'h1e40, z);
			rc(16'h1e44, z);
			chk(32'(chain_bit_timing), z);
			chk(32'(chain_timing_locked), z);
			chk(32'(irq), z);
		end
	endtask
	initial begin
		#20000;
		failures = failures + 1;
		test_done;
	end
	initial begin
		repeat (3) @(posedge sys_clk);
		rst <= 0;
		t_reset;
		t_crc_irq;
		t_ignore;
		t_chain;
		t_mid_reset;
		test_done;
	end
endmodule
